// [src/sea_pkg.sv]
/*
 * Package for the serial EEPROM access command block: command-byte field
 * positions, request byte positions, reset values and the packed carriers.
 * Assumes a single 100 MHz core clock and a synchronous active-high reset.
 */
// Behaviour
// - Command bit 0 selects the access direction: 0 writes the EEPROM, 1 reads it.
// - With command bit 1 set the given device-address byte is used, else the default bus address.
// - Command bit 3 is set on an unexpected not-acknowledge in the master transfer, cleared on read.
// - Command bit 4 is set when 16 arbitration attempts in a row are lost, cleared on read.
// - Command bit 5 is set on a misplaced START or STOP in the master transfer, cleared on read.
// - The three error bits mean the same as the matching port status register error bits.
// - A request is command code, byte count (block only), command, address byte, low, high, data.
// - The byte count is present only for block transfers and counts the following bytes.
package sea_pkg;
    localparam int CMD_DIR_BIT = 0;
    localparam int CMD_USA_BIT = 1;
    localparam int CMD_NACK_BIT = 3;
    localparam int CMD_ARB_BIT = 4;
    localparam int CMD_MISP_BIT = 5;
    localparam logic [7:0] CMD_RSVD_MASK = 8'hC4;
    localparam logic [7:0] CMD_ERR_MASK = 8'h38;
    // byte positions within a request, counting from the command code
    localparam logic [2:0] POS_COMMAND_CODE = 3'h0;
    localparam logic [2:0] POS_BCNT = 3'h1;
    localparam logic [2:0] POS_CMD = 3'h2;
    localparam logic [2:0] POS_DADDR = 3'h3;
    localparam logic [2:0] POS_EEPROM_ADDRESS_LOW = 3'h4;
    localparam logic [2:0] POS_ADDRH = 3'h5;
    localparam logic [2:0] POS_DATA = 3'h6;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [4:0] ARB_LIMIT = 5'h10;
    localparam logic [7:0] DEFAULT_ADDR_RST = 8'hA0;

    // request handed to the master engine
    typedef struct packed {
        logic read;
        logic [6:0] dev_addr;
        logic [15:0] byte_addr;
        logic [7:0] wdata;
    } sea_req_t;

    // outcome reported by the master engine for one transfer
    typedef struct packed {
        logic done;
        logic nack;
        logic arb_lost;
        logic misplaced;
        logic [7:0] rdata;
    } sea_rsp_t;
endpackage : sea_pkg

// [src/sea_err_flag.sv]
/*
 * One sticky read-to-clear error flag with the set winning over the clear.
 * Assumes set and clear are single-cycle strobes on the core clock.
 */
`timescale 1ns/100ps
module sea_err_flag (
    // clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // events
    input wire logic set,
    input wire logic clr,
    // state
    output logic flag
);
    logic flag_q;
    logic flag_d;

    // a set in the clearing cycle survives so no event is lost
    always_comb begin
        flag_d = flag_q;
        if (clr) begin
            flag_d = 1'b0;
        end
        if (set) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (clk_en) begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;

    set_wins_a: assert property (@(posedge clk) disable iff (rst)
        (clk_en && set) |=> flag_q) else $error("flag lost a set event");
endmodule : sea_err_flag

// [src/sea_access_cmd.sv]
/*
 * Serial EEPROM access command block: takes request bytes from the slave
 * byte sequencer, starts the master engine, gathers error bits and returns
 * the command byte and data byte to the host's next read.
 * Assumes the sequencer gives one byte strobe per byte with its position, and
 * the master engine reports one done pulse per start, with error strobes.
 */
`timescale 1ns/100ps
module sea_access_cmd
    import sea_pkg::*;
#(
    parameter int ARB_TRIES = int'(ARB_LIMIT)
) (
    // clock and control
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // slave byte sequencer, write side
    input wire logic wr_stb,
    input wire logic [2:0] wr_pos,
    input wire logic [7:0] wr_byte,
    input wire logic req_end,
    // slave byte sequencer, read side
    input wire logic rd_stb,
    input wire logic [2:0] rd_pos,
    output logic [7:0] rd_byte,
    // default bus address from the status register
    input wire logic [7:0] default_eeprom_bus_address,
    // master engine
    output logic start,
    output sea_req_t req,
    input wire logic arb_lost_try,
    input wire sea_rsp_t rsp,
    // status
    output logic busy,
    output logic [2:0] err_bits
);
    typedef enum logic [2:0] {
        SEA_IDLE = 3'b001,
        SEA_RUN = 3'b010,
        SEA_DONE = 3'b100
    } sea_state_t;

    // refuse counts that the 5-bit attempt counter cannot reach
    if (ARB_TRIES < 1 || ARB_TRIES > 31) begin : g_bad_tries
        $error("ARB_TRIES out of range");
    end

    localparam logic [4:0] ARB_MAX = 5'(ARB_TRIES);

    sea_state_t st_q, st_d;
    logic [7:0] cmd_q, cmd_d;
    logic [7:0] daddr_q, daddr_d;
    logic [15:0] baddr_q, baddr_d;
    logic [7:0] data_q, data_d;
    logic [4:0] arb_q, arb_d;
    logic [7:0] rd_q, rd_d;
    logic start_q, start_d;
    sea_req_t req_q, req_d;
    logic busy_q, busy_d;
    logic [2:0] err_set;
    logic err_clr;
    logic [2:0] err_flag;

    // picks the bus address: the given one when asked, else the default
    function automatic logic [6:0] pick_addr(input logic [7:0] cmd, input logic [7:0] given,
                                             input logic [7:0] dflt);
        pick_addr = cmd[CMD_USA_BIT] ? given[7:1] : dflt[7:1];
    endfunction : pick_addr

    // request capture and transfer sequencing
    always_comb begin
        st_d = st_q;
        cmd_d = cmd_q;
        daddr_d = daddr_q;
        baddr_d = baddr_q;
        data_d = data_q;
        arb_d = arb_q;
        start_d = 1'b0;
        err_set = 3'b000;
        // bytes land by position; the byte count is ignored here
        if (wr_stb && st_q == SEA_IDLE) begin
            case (wr_pos)
                POS_CMD: cmd_d = wr_byte & ~(CMD_RSVD_MASK | CMD_ERR_MASK);
                POS_DADDR: daddr_d = wr_byte;
                POS_EEPROM_ADDRESS_LOW: baddr_d[7:0] = wr_byte;
                POS_ADDRH: baddr_d[15:8] = wr_byte;
                POS_DATA: data_d = wr_byte;
                default: ;
            endcase
        end
        case (st_q)
            SEA_IDLE: begin
                if (req_end) begin
                    st_d = SEA_RUN;
                    start_d = 1'b1;
                    arb_d = 5'h00;
                end
            end
            SEA_RUN: begin
                if (arb_lost_try) begin
                    arb_d = arb_q + 5'h01;
                    if (arb_q + 5'h01 >= ARB_MAX) begin
                        err_set[1] = 1'b1;
                        st_d = SEA_DONE;
                    end
                end
                if (rsp.done) begin
                    err_set[0] = rsp.nack;
                    err_set[2] = rsp.misplaced;
                    if (rsp.arb_lost) begin
                        err_set[1] = 1'b1;
                    end
                    if (cmd_q[CMD_DIR_BIT]) begin
                        data_d = rsp.rdata;
                    end
                    st_d = SEA_DONE;
                end
            end
            SEA_DONE: st_d = SEA_IDLE;
            default: st_d = SEA_IDLE;
        endcase
        // request built from the next values, so the engine never sees a live input mux
        req_d.read = cmd_d[CMD_DIR_BIT];
        req_d.dev_addr = pick_addr(cmd_d, daddr_d, default_eeprom_bus_address);
        req_d.byte_addr = baddr_d;
        req_d.wdata = data_d;
        busy_d = (st_d != SEA_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= SEA_IDLE;
            cmd_q <= RESET_BYTE;
            daddr_q <= RESET_BYTE;
            baddr_q <= 16'h0000;
            data_q <= RESET_BYTE;
            arb_q <= 5'h00;
            start_q <= 1'b0;
            req_q <= '0;
            busy_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            cmd_q <= cmd_d;
            daddr_q <= daddr_d;
            baddr_q <= baddr_d;
            data_q <= data_d;
            arb_q <= arb_d;
            start_q <= start_d;
            req_q <= req_d;
            busy_q <= busy_d;
        end
    end

    // error flags share the meaning of the port status register bits
    assign err_clr = clk_en && rd_stb && rd_pos == POS_CMD;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_err
            sea_err_flag u_flag (
                .clk(clk),
                .rst(rst),
                .clk_en(clk_en),
                .set(err_set[gi]),
                .clr(err_clr),
                .flag(err_flag[gi])
            );
        end
    endgenerate

    // read-back byte; registered so the host sees a stable value
    always_comb begin
        rd_d = rd_q;
        if (rd_stb) begin
            case (rd_pos)
                POS_CMD: begin
                    rd_d = cmd_q;
                    rd_d[CMD_NACK_BIT] = err_flag[0];
                    rd_d[CMD_ARB_BIT] = err_flag[1];
                    rd_d[CMD_MISP_BIT] = err_flag[2];
                end
                POS_DADDR: rd_d = daddr_q;
                POS_EEPROM_ADDRESS_LOW: rd_d = baddr_q[7:0];
                POS_ADDRH: rd_d = baddr_q[15:8];
                POS_DATA: rd_d = data_q;
                default: rd_d = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_q <= RESET_BYTE;
        end else if (clk_en) begin
            rd_q <= rd_d;
        end
    end

    // every output leaves straight from a register; while busy the request changes only with the default address input and, on a read, with the data at done
    assign rd_byte = rd_q;
    assign start = start_q;
    assign req = req_q;
    assign busy = busy_q;
    assign err_bits = err_flag;

    start_once_a: assert property (@(posedge clk) disable iff (rst)
        (clk_en && st_q == SEA_IDLE && req_end) |=> start_q && st_q == SEA_RUN)
        else $error("accepted request did not start");
    dir_bit_a: assert property (@(posedge clk) disable iff (rst)
        req.read == cmd_q[CMD_DIR_BIT]) else $error("direction not from bit 0");
    addr_pick_a: assert property (@(posedge clk) disable iff (rst)
        cmd_q[CMD_USA_BIT] |-> req.dev_addr == daddr_q[7:1])
        else $error("given address unused");
    dflt_pick_a: assert property (@(posedge clk) disable iff (rst)
        (clk_en && !cmd_d[CMD_USA_BIT]) |=>
        {req.dev_addr, 1'b0} == ($past(default_eeprom_bus_address) & 8'hFE))
        else $error("default address unused");
    nack_set_a: assert property (@(posedge clk) disable iff (rst)
        (clk_en && st_q == SEA_RUN && rsp.done && rsp.nack) |=> err_flag[0])
        else $error("nack not flagged");
    arb_lim_a: assert property (@(posedge clk) disable iff (rst)
        (clk_en && st_q == SEA_RUN && arb_lost_try && arb_q == ARB_MAX - 5'h01) |=> err_flag[1])
        else $error("arbitration loss not flagged");
    misp_set_a: assert property (@(posedge clk) disable iff (rst)
        (clk_en && st_q == SEA_RUN && rsp.done && rsp.misplaced) |=> err_flag[2])
        else $error("misplaced condition not flagged");
    rsvd_zero_a: assert property (@(posedge clk) disable iff (rst)
        (cmd_q & CMD_RSVD_MASK) == 8'h00) else $error("reserved bits stored");
    rc_clear_a: assert property (@(posedge clk) disable iff (rst)
        (err_clr && err_set == 3'b000) |=> err_flag == 3'b000)
        else $error("read did not clear errors");
endmodule : sea_access_cmd

// [sim/sea_engine_model.sv]
/*
 * Behavioural master engine facing the access command block.
 * Assumes start is a one-cycle pulse and the request stays stable while busy.
 */
`timescale 1ns/100ps
module sea_engine_model
    import sea_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // from the block
    input wire logic start,
    input wire sea_req_t req,
    // outcome choice: 0 ok, 1 nack, 2 misplaced, 3 lost arbitration
    input wire logic [1:0] mode,
    input wire logic [7:0] rdata,
    input wire logic [4:0] tries,
    // to the block
    output logic arb_lost_try,
    output sea_rsp_t rsp
);
    // one transfer per start; outside the done cycle the data is inverted garbage
    initial begin
        arb_lost_try = 1'b0;
        rsp = '{1'b0, 1'b0, 1'b0, 1'b0, ~rdata};
        forever begin
            @(posedge clk);
            if (start && !rst) begin
                repeat (2) @(posedge clk);
                if (mode == 2'h3) begin
                    // lost tries spaced by an idle cycle; the block ends it itself
                    repeat (tries) begin
                        arb_lost_try <= 1'b1;
                        @(posedge clk);
                        arb_lost_try <= 1'b0;
                        @(posedge clk);
                    end
                end else begin
                    // done carries the outcome and read data together
                    rsp <= '{1'b1, mode == 2'h1, 1'b0, mode == 2'h2, req.read ? rdata : ~rdata};
                    @(posedge clk);
                    rsp <= '{1'b0, 1'b0, 1'b0, 1'b0, ~rdata};
                end
            end
        end
    end
endmodule : sea_engine_model

// [sim/smbus_eeprom_access_command_bench.sv]
/*
 * Self-checking bench for the access command block, one task per scenario.
 * Assumes the engine model answers every start it sees.
 */
`timescale 1ns/100ps
module smbus_eeprom_access_command_bench
    import sea_pkg::*;
;
    localparam int TRIES = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic wr_stb = 1'b0;
    logic req_end = 1'b0;
    logic rd_stb = 1'b0;
    logic [2:0] wr_pos = 3'h0;
    logic [2:0] rd_pos = 3'h0;
    logic [7:0] wr_byte = 8'h00;
    logic [7:0] dflt = 8'hA6;
    logic [7:0] rd_byte;
    logic [7:0] rdv;
    logic [1:0] mode = 2'h0;
    logic start;
    logic busy;
    logic arb_try;
    logic [2:0] err_bits;
    sea_req_t req;
    sea_req_t cap;
    sea_rsp_t rsp;
    int error_cnt = 0;
    int n_compared = 0;

    sea_access_cmd #(.ARB_TRIES(TRIES)) u_dut (.clk(clk), .rst(rst), .clk_en(clk_en),
        .wr_stb(wr_stb), .wr_pos(wr_pos), .wr_byte(wr_byte), .req_end(req_end),
        .rd_stb(rd_stb), .rd_pos(rd_pos), .rd_byte(rd_byte),
        .default_eeprom_bus_address(dflt), .start(start), .req(req),
        .arb_lost_try(arb_try), .rsp(rsp), .busy(busy), .err_bits(err_bits));
    sea_engine_model u_eng (.clk(clk), .rst(rst), .start(start), .req(req), .mode(mode),
        .rdata(8'h5A), .tries(5'(TRIES)), .arb_lost_try(arb_try), .rsp(rsp));

    // free-running 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // widest field is 16 bits, so narrower values are zero-extended
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // host order: cmd, device address, low, high, data, then stop; reserved bits kept 0
    task automatic run(input logic [7:0] cmd, da, al, ah, dat, input logic [1:0] m);
        logic [7:0] b [5];
        int i;
        b = '{cmd, da, al, ah, dat};
        for (i = 0; i < 5; i++) begin
            @(posedge clk);
            wr_stb <= 1'b1;
            mode <= m;
            wr_pos <= POS_CMD + 3'(i);
            wr_byte <= b[i];
        end
        @(posedge clk);
        wr_stb <= 1'b0;
        req_end <= 1'b1;
        @(posedge clk);
        req_end <= 1'b0;
        #1;
        cmp("start", 16'h1, {15'h0, start});
        cap = req;
        for (i = 0; i < 60; i++) begin
            @(posedge clk);
            #1;
            if (busy === 1'b0) break;
        end
        if (i == 60) begin
            error_cnt++;
            $display("[ERR] busy expected 0 seen %b", busy);
            test_done();
        end
    endtask : run

    // read one position; rd_byte lands on the edge that samples rd_stb
    task automatic rd(input logic [2:0] p);
        @(posedge clk);
        rd_stb <= 1'b1;
        rd_pos <= p;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        rdv = rd_byte;
    endtask : rd

    task automatic t_write();
        run(8'h00, 8'h5E, 8'h34, 8'h12, 8'h9C, 2'h0);
        cmp("read", 16'h0, {15'h0, cap.read});
        cmp("dev_addr", {9'h0, dflt[7:1]}, {9'h0, cap.dev_addr});
        cmp("byte_addr", 16'h1234, cap.byte_addr);
        cmp("wdata", 16'h009C, {8'h0, cap.wdata});
        rd(POS_CMD);
        cmp("cmd", 16'h0000, {8'h0, rdv});
        // a write must not take the engine's returned byte
        rd(POS_DATA);
        cmp("wr data", 16'h009C, {8'h0, rdv});
        $display("write with default address done");
    endtask : t_write

    task automatic t_read();
        run(8'h03, 8'hAE, 8'hFF, 8'h00, 8'h11, 2'h0);
        cmp("read", 16'h1, {15'h0, cap.read});
        cmp("dev_addr", 16'h0057, {9'h0, cap.dev_addr});
        cmp("byte_addr", 16'h00FF, cap.byte_addr);
        rd(POS_DATA);
        cmp("rdata", 16'h005A, {8'h0, rdv});
        rd(POS_CMD);
        cmp("cmd", 16'h0003, {8'h0, rdv});
        $display("read with given address done");
    endtask : t_read

    // an error shows in err_bits and in the command byte, then clears on read
    task automatic err_case(input logic [1:0] m, input int b);
        run(8'h01, 8'hA0, 8'h00, 8'h00, 8'h00, m);
        cmp("err_bits", 16'(1 << (b - 3)), {13'h0, err_bits});
        rd(POS_CMD);
        cmp("cmd set", 16'h0001 | 16'(1 << b), {8'h0, rdv});
        rd(POS_CMD);
        cmp("cmd clr", 16'h0001, {8'h0, rdv});
        $display("error case for bit %0d done", b);
    endtask : err_case

    // with the enable low a read must neither load rd_byte nor clear the flags
    task automatic t_freeze();
        logic [7:0] held;
        run(8'h01, 8'hA0, 8'h00, 8'h00, 8'h00, 2'h1);
        held = rd_byte;
        @(posedge clk);
        clk_en <= 1'b0;
        rd(POS_CMD);
        cmp("frozen rd_byte", {8'h0, held}, {8'h0, rdv});
        cmp("frozen err_bits", 16'h0001, {13'h0, err_bits});
        @(posedge clk);
        clk_en <= 1'b1;
        rd(POS_CMD);
        cmp("cmd after freeze", 16'h0009, {8'h0, rdv});
        cmp("err_bits after read", 16'h0000, {13'h0, err_bits});
        $display("clock enable freeze done");
    endtask : t_freeze

    task automatic t_nack();
        err_case(2'h1, CMD_NACK_BIT);
    endtask : t_nack

    task automatic t_arb();
        err_case(2'h3, CMD_ARB_BIT);
    endtask : t_arb

    task automatic t_misp();
        err_case(2'h2, CMD_MISP_BIT);
    endtask : t_misp

    // main sequence: 8 cycles of reset, then every scenario
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_write();
        t_read();
        t_nack();
        t_arb();
        t_misp();
        t_freeze();
        test_done();
    end
endmodule : smbus_eeprom_access_command_bench
